// *** src/spio_divider.sv ***
// Feedback divider: encoder counts in, A/B/index quadrature out
`timescale 1ns/1ps
module spio_divider #(
  parameter int ENC_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ENC_W-1:0] enc_res_i,
  input wire logic [15:0] ppr_i,
  input wire logic swap_i,
  input wire logic enc_step_i,
  input wire logic enc_dir_i,
  input wire logic step_ok_i,
  output logic a_o,
  output logic b_o,
  output logic idx_o,
  output logic step_o
);
  logic [ENC_W+1:0] acc_q, acc_d;
  logic [1:0] ph_q, ph_d;
  logic [15:0] pend_q, pend_d;
  logic pdir_q, pdir_d;
  logic [17:0] qcnt_q, qcnt_d;
  logic [17:0] qmax;
  logic step;

  assign qmax = {ppr_i, 2'b00} - 18'h00001;

  // Bresenham: add 4*ppr per encoder count, step per full resolution
  always_comb begin
    acc_d = acc_q;
    pend_d = pend_q;
    pdir_d = pdir_q;
    ph_d = ph_q;
    qcnt_d = qcnt_q;
    step = 1'b0;
    if (enc_step_i) begin
      acc_d = acc_q + {{(ENC_W-16){1'b0}}, ppr_i, 2'b00};
      if (acc_d >= {2'b00, enc_res_i}) begin
        acc_d = acc_d - {2'b00, enc_res_i};
        pend_d = pend_q + 16'h0001;
        pdir_d = enc_dir_i;
      end
    end
    // Output rate capped by step_ok_i pacing
    if (pend_q != 16'h0000 && step_ok_i) begin
      step = 1'b1;
      pend_d = pend_d - 16'h0001;
      if (pdir_q) begin
        ph_d = ph_q + 2'b01;
        qcnt_d = (qcnt_q == qmax) ? 18'h00000 : qcnt_q + 18'h00001;
      end else begin
        ph_d = ph_q - 2'b01;
        qcnt_d = (qcnt_q == 18'h00000) ? qmax : qcnt_q - 18'h00001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
      pend_q <= 16'h0000;
      pdir_q <= 1'b0;
      ph_q <= 2'b00;
      qcnt_q <= 18'h00000;
    end else begin
      acc_q <= acc_d;
      pend_q <= pend_d;
      pdir_q <= pdir_d;
      ph_q <= ph_d;
      qcnt_q <= qcnt_d;
    end
  end

  // Gray sequence 00,01,11,10 gives 90 degree A/B swap reverses
  logic a_d, b_d, idx_d;
  always_comb begin
    a_d = ph_q[1] ^ ph_q[0];
    b_d = ph_q[1];
    if (swap_i) begin
      a_d = ph_q[1];
      b_d = ph_q[1] ^ ph_q[0];
    end
    // Index high during the first unswapped A-high span of each turn
    idx_d = (qcnt_q == 18'h00001) || (qcnt_q == 18'h00002);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_o <= 1'b0;
      b_o <= 1'b0;
      idx_o <= 1'b0;
      step_o <= 1'b0;
    end else begin
      a_o <= a_d;
      b_o <= b_d;
      idx_o <= idx_d;
      step_o <= step;
    end
  end
endmodule : spio_divider

// *** src/spio_filter.sv ***
// Input glitch filter for one reference pulse line
`timescale 1ns/1ps
module spio_filter #(
  parameter int CW = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_i,
  input wire logic [CW-1:0] len_i,
  output logic out_o
);
  logic [CW-1:0] cnt_q, cnt_d;
  logic out_q, out_d;

  // Level must stand len_i + 1 cycles before it is passed on
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (in_i == out_q) begin
      cnt_d = '0;
    end else if (cnt_q >= len_i) begin
      out_d = in_i;
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign out_o = out_q;
endmodule : spio_filter

// *** src/spio_pkg.sv ***
// Package for the servo pulse input/output block: register map and constants
package spio_pkg;
  // Wishbone register word offsets (byte addresses)
  localparam logic [7:0] ADDR_PPR = 8'h00;
  localparam logic [7:0] ADDR_WINDOW = 8'h04;
  localparam logic [7:0] ADDR_FORM = 8'h08;
  localparam logic [7:0] ADDR_FILTER = 8'h0c;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_APPLY = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_POS = 8'h1c;
  localparam logic [7:0] ADDR_SPEED = 8'h20;
  // Reset values and limits
  localparam logic [15:0] PPR_RESET = 16'h09c4;
  localparam logic [15:0] PPR_MIN = 16'h0010;
  localparam logic [15:0] PPR_MAX = 16'h3fff;
  localparam logic [15:0] WINDOW_RESET = 16'h000a;
  localparam logic [15:0] WINDOW_MAX = 16'h0064;
  localparam logic [15:0] FORM_RESET = 16'h0000;
  localparam logic [15:0] FILTER_RESET = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // Pulse form codes (low digit)
  localparam logic [3:0] FORM_SIGN_POS = 4'h0;
  localparam logic [3:0] FORM_CWCCW_POS = 4'h1;
  localparam logic [3:0] FORM_QUAD_X1 = 4'h2;
  localparam logic [3:0] FORM_QUAD_X2 = 4'h3;
  localparam logic [3:0] FORM_QUAD_X4 = 4'h4;
  localparam logic [3:0] FORM_SIGN_NEG = 4'h5;
  localparam logic [3:0] FORM_CWCCW_NEG = 4'h6;
  // Control mode codes (second digit)
  localparam logic [3:0] MODE_SPEED = 4'h0;
  localparam logic [3:0] MODE_POSITION = 4'h1;
  // Field positions
  localparam int FILT_BIT = 8;
  localparam int SWAP_BIT = 4;
  localparam int MODE_LSB = 4;
  // Status bits
  localparam int ST_MISMATCH = 0;
  localparam int ST_OVERSPEED = 1;
  localparam int ST_MATCH = 2;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int FILT_HS_NS = 125;
  localparam int FILT_LS_NS = 625;
  localparam int FILT_HS_CYC = (FILT_HS_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int FILT_LS_CYC = (FILT_LS_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int FB_MAX_PPS = 1_600_000;
  localparam int FB_STEP_HZ = 4 * FB_MAX_PPS;
  localparam int FB_STEP_CYC = CLK_HZ / FB_STEP_HZ;
  localparam logic [15:0] SPEED_LIMIT_RPM = 16'd6000;
endpackage : spio_pkg

// *** src/spio_top.sv ***
// Servo pulse input/output block with Wishbone register access
`timescale 1ns/1ps
module spio_top #(
  parameter int ENC_W = 24,
  parameter logic [ENC_W-1:0] ENC_RES = 24'd131072
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ref_pulse_in_i,
  input wire logic ref_sign_in_i,
  input wire logic enc_step_i,
  input wire logic enc_dir_i,
  input wire logic [15:0] motor_speed_i,
  input wire logic motor_speed_neg_i,
  input wire logic [15:0] speed_cmd_i,
  input wire logic speed_cmd_neg_i,
  output logic feedback_phase_a_o,
  output logic feedback_phase_b_o,
  output logic feedback_index_o,
  output logic speed_match_out_o,
  output logic position_mode_o,
  output logic ref_step_o,
  output logic ref_dir_o,
  output logic alarm_mismatch_o,
  output logic alarm_overspeed_o
);
  import spio_pkg::*;

  // Live copies written by software, active copies taken at apply
  logic [15:0] ppr_q, ppr_d, win_q, win_d, form_q, form_d;
  logic [15:0] filt_q, filt_d, mode_q, mode_d;
  logic [15:0] ppr_a_q, ppr_a_d, form_a_q, form_a_d;
  logic [15:0] filt_a_q, filt_a_d, mode_a_q, mode_a_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [31:0] pos_q, pos_d;
  logic req, wr;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;

  // Register writes; low two byte lanes carry the 16-bit fields
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    merge = old;
    if (sel[0]) begin
      merge[7:0] = d[7:0];
    end
    if (sel[1]) begin
      merge[15:8] = d[15:8];
    end
  endfunction : merge

  logic [15:0] win_w;
  logic mismatch;
  logic overspeed;
  logic match;
  always_comb begin
    ppr_d = ppr_q;
    win_d = win_q;
    form_d = form_q;
    filt_d = filt_q;
    mode_d = mode_q;
    ppr_a_d = ppr_a_q;
    form_a_d = form_a_q;
    filt_a_d = filt_a_q;
    mode_a_d = mode_a_q;
    win_w = merge(win_q, wb_dat_i, wb_sel_i);
    if (wr) begin
      case (wb_adr_i)
        ADDR_PPR: ppr_d = merge(ppr_q, wb_dat_i, wb_sel_i);
        // Window clamped to its range, used at once
        ADDR_WINDOW: win_d = (win_w > WINDOW_MAX) ? WINDOW_MAX : win_w;
        ADDR_FORM: form_d = merge(form_q, wb_dat_i, wb_sel_i);
        ADDR_FILTER: filt_d = merge(filt_q, wb_dat_i, wb_sel_i);
        ADDR_MODE: mode_d = merge(mode_q, wb_dat_i, wb_sel_i);
        // Stands in for power cycling: copy settings to active set
        ADDR_APPLY: begin
          ppr_a_d = ppr_q;
          form_a_d = form_q;
          filt_a_d = filt_q;
          mode_a_d = mode_q;
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero and still acknowledge
  always_comb begin
    ack_d = req;
    rdat_d = 32'h00000000;
    case (wb_adr_i)
      ADDR_PPR: rdat_d = {16'h0000, ppr_q};
      ADDR_WINDOW: rdat_d = {16'h0000, win_q};
      ADDR_FORM: rdat_d = {16'h0000, form_q};
      ADDR_FILTER: rdat_d = {16'h0000, filt_q};
      ADDR_MODE: rdat_d = {16'h0000, mode_q};
      ADDR_STATUS: begin
        rdat_d[ST_MISMATCH] = alarm_mismatch_o;
        rdat_d[ST_OVERSPEED] = alarm_overspeed_o;
        rdat_d[ST_MATCH] = speed_match_out_o;
      end
      ADDR_POS: rdat_d = pos_q;
      ADDR_SPEED: rdat_d = {16'h0000, motor_speed_i};
      default: rdat_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ppr_q <= PPR_RESET;
      win_q <= WINDOW_RESET;
      form_q <= FORM_RESET;
      filt_q <= FILTER_RESET;
      mode_q <= MODE_RESET;
      ppr_a_q <= PPR_RESET;
      form_a_q <= FORM_RESET;
      filt_a_q <= FILTER_RESET;
      mode_a_q <= MODE_RESET;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ppr_q <= ppr_d;
      win_q <= win_d;
      form_q <= form_d;
      filt_q <= filt_d;
      mode_q <= mode_d;
      ppr_a_q <= ppr_a_d;
      form_a_q <= form_a_d;
      filt_a_q <= filt_a_d;
      mode_a_q <= mode_a_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Input filters; length chosen by the active filter setting
  logic [6:0] flen;
  logic p_f, s_f;
  assign flen = filt_a_q[FILT_BIT] ? 7'(FILT_LS_CYC) : 7'(FILT_HS_CYC);

  spio_filter #(.CW(7)) u_filt_p (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i(ref_pulse_in_i),
    .len_i(flen),
    .out_o(p_f)
  );

  spio_filter #(.CW(7)) u_filt_s (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i(ref_sign_in_i),
    .len_i(flen),
    .out_o(s_f)
  );

  // Reference pulse decoder
  logic p_q, s_q;
  logic step_d, dir_d;
  logic p_rise, s_rise, p_edge, s_edge;
  logic [3:0] form;
  logic posmode;
  assign form = form_a_q[3:0];
  assign posmode = (mode_a_q[MODE_LSB +: 4] == MODE_POSITION);
  assign p_rise = p_f && !p_q;
  assign s_rise = s_f && !s_q;
  assign p_edge = p_f ^ p_q;
  assign s_edge = s_f ^ s_q;

  always_comb begin
    step_d = 1'b0;
    dir_d = 1'b0;
    case (form)
      FORM_SIGN_POS: begin
        step_d = p_rise;
        dir_d = s_f;
      end
      FORM_SIGN_NEG: begin
        step_d = p_rise;
        dir_d = !s_f;
      end
      FORM_CWCCW_POS: begin
        step_d = p_rise ^ s_rise;
        dir_d = p_rise;
      end
      FORM_CWCCW_NEG: begin
        step_d = (p_q && !p_f) ^ (s_q && !s_f);
        dir_d = p_q && !p_f;
      end
      // B leads A forward: A rising with B high
      FORM_QUAD_X1: begin
        step_d = p_rise;
        dir_d = s_f;
      end
      FORM_QUAD_X2: begin
        step_d = p_edge;
        dir_d = (p_f == s_f);
      end
      FORM_QUAD_X4: begin
        step_d = p_edge || s_edge;
        dir_d = p_edge ? (p_f == s_f) : (p_f != s_f);
      end
      default: begin
        step_d = 1'b0;
        dir_d = 1'b0;
      end
    endcase
    if (!posmode) begin
      step_d = 1'b0;
    end
  end

  // Position counter: pulse count sets distance, rate sets speed
  always_comb begin
    pos_d = pos_q;
    if (step_d) begin
      pos_d = dir_d ? pos_q + 32'h00000001 : pos_q - 32'h00000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_q <= 1'b0;
      s_q <= 1'b0;
      pos_q <= 32'h00000000;
      ref_step_o <= 1'b0;
      ref_dir_o <= 1'b0;
      position_mode_o <= 1'b0;
    end else begin
      p_q <= p_f;
      s_q <= s_f;
      pos_q <= pos_d;
      ref_step_o <= step_d;
      ref_dir_o <= dir_d;
      position_mode_o <= posmode;
    end
  end

  // Pacing counter limits feedback steps to about 1.6 Mpps per phase
  logic [7:0] pace_q, pace_d;
  logic pace_ok, fb_step;
  assign pace_ok = (pace_q == 8'h00);
  always_comb begin
    pace_d = pace_q;
    if (fb_step) begin
      pace_d = 8'(FB_STEP_CYC - 1);
    end else if (!pace_ok) begin
      pace_d = pace_q - 8'h01;
    end
  end

  spio_divider #(.ENC_W(ENC_W)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enc_res_i(ENC_RES),
    .ppr_i(ppr_a_q),
    .swap_i(filt_a_q[SWAP_BIT]),
    .enc_step_i(enc_step_i),
    .enc_dir_i(enc_dir_i),
    .step_ok_i(pace_ok && !fb_step),
    .a_o(feedback_phase_a_o),
    .b_o(feedback_phase_b_o),
    .idx_o(feedback_index_o),
    .step_o(fb_step)
  );

  // Alarms and speed match
  logic [16:0] serr;
  always_comb begin
    mismatch = (ppr_a_q < PPR_MIN) || (ppr_a_q > PPR_MAX)
               || ({{(ENC_W-16){1'b0}}, ppr_a_q} > ENC_RES);
    overspeed = motor_speed_i > SPEED_LIMIT_RPM;
    if (motor_speed_neg_i == speed_cmd_neg_i) begin
      serr = (motor_speed_i > speed_cmd_i)
             ? {1'b0, motor_speed_i - speed_cmd_i}
             : {1'b0, speed_cmd_i - motor_speed_i};
    end else begin
      serr = {1'b0, motor_speed_i} + {1'b0, speed_cmd_i};
    end
    // Only meaningful in speed control; held open otherwise
    match = (serr < {1'b0, win_q}) && !posmode;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pace_q <= 8'h00;
      alarm_mismatch_o <= 1'b0;
      alarm_overspeed_o <= 1'b0;
      speed_match_out_o <= 1'b0;
    end else begin
      pace_q <= pace_d;
      alarm_mismatch_o <= mismatch;
      alarm_overspeed_o <= overspeed;
      speed_match_out_o <= match;
    end
  end
endmodule : spio_top

// *** verification/spio_host.sv ***
// Host controller model issuing reference pulse bursts
`timescale 1ns/1ps
module spio_host #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] kind_i,
  input wire logic neg_i,
  input wire logic fwd_i,
  input wire logic [7:0] hp_i,
  output logic pulse_o,
  output logic sign_o,
  output logic busy_o
);
  initial begin
    pulse_o = 1'b0;
    sign_o = 1'b0;
    busy_o = 1'b0;
  end
  // Kind 0 sign+pulse, 1 two lines, 2 quadrature; lines idle low
  task automatic run();
    int k;
    logic mid;
    logic lo;
    busy_o <= 1'b1;
    if (kind_i == 3'd0) sign_o <= fwd_i ^ neg_i;
    // Start gap, shortened so the run stays brief
    repeat (hp_i) @(posedge clk_i);
    for (k = 0; k < (kind_i == 3'd2 ? 4 : 2) * N; k++) begin
      mid = (k % 4 == 1) || (k % 4 == 2);
      lo = (k % 4) < 2;
      if (kind_i == 3'd2) begin
        pulse_o <= fwd_i ? mid : lo;
        sign_o <= fwd_i ? lo : mid;
      end else if (kind_i == 3'd1 && !fwd_i) begin
        sign_o <= !k[0];
      end else begin
        pulse_o <= !k[0];
      end
      repeat (hp_i) @(posedge clk_i);
    end
    sign_o <= 1'b0;
    busy_o <= 1'b0;
  endtask : run
  always @(posedge clk_i) begin
    if (go_i && !busy_o) run();
  end
endmodule : spio_host

// *** verification/spio_top_chk.sv ***
// Port-level assertions for the servo pulse block
`timescale 1ns/1ps
module spio_top_chk import spio_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [15:0] motor_speed_i,
  input wire logic wb_ack_o,
  input wire logic feedback_phase_a_o,
  input wire logic feedback_phase_b_o,
  input wire logic speed_match_out_o,
  input wire logic position_mode_o,
  input wire logic ref_step_o,
  input wire logic alarm_overspeed_o
);
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic [1:0] ab_q;
  logic [1:0] ab_d;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since the last feedback edge, saturating so reset never fails
  always_comb begin
    ab_d = {feedback_phase_a_o, feedback_phase_b_o};
    gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
    if (ab_d != ab_q) gap_d = 8'h00;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_q <= 8'hff;
      ab_q <= 2'b00;
    end else begin
      gap_q <= gap_d;
      ab_q <= ab_d;
    end
  end
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_no_req;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_no_req: assert property (p_no_req) else $error("ack unasked");
  property p_ovs_hi;
    (motor_speed_i > SPEED_LIMIT_RPM) [*3] |-> alarm_overspeed_o;
  endproperty
  a_ovs_hi: assert property (p_ovs_hi) else $error("no overspeed");
  property p_ovs_lo;
    (motor_speed_i <= SPEED_LIMIT_RPM) [*3] |-> !alarm_overspeed_o;
  endproperty
  a_ovs_lo: assert property (p_ovs_lo) else $error("false overspeed");
  property p_match_mode;
    position_mode_o && $past(position_mode_o) |-> !speed_match_out_o;
  endproperty
  a_match_mode: assert property (p_match_mode) else $error("match");
  property p_step_mode;
    ref_step_o |-> position_mode_o || $past(position_mode_o);
  endproperty
  a_step_mode: assert property (p_step_mode) else $error("step");
  property p_gray;
    $changed(feedback_phase_a_o) |-> $stable(feedback_phase_b_o);
  endproperty
  a_gray: assert property (p_gray) else $error("A and B moved");
  property p_pace;
    ab_d != ab_q |-> gap_q >= 8'd14;
  endproperty
  a_pace: assert property (p_pace) else $error("feedback fast");
endmodule : spio_top_chk
bind spio_top spio_top_chk spio_top_chk_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .motor_speed_i(motor_speed_i),
  .wb_ack_o(wb_ack_o),
  .feedback_phase_a_o(feedback_phase_a_o),
  .feedback_phase_b_o(feedback_phase_b_o),
  .speed_match_out_o(speed_match_out_o),
  .position_mode_o(position_mode_o),
  .ref_step_o(ref_step_o),
  .alarm_overspeed_o(alarm_overspeed_o)
);

// *** verification/spio_top_tb_top.sv ***
// Self-checking testbench for the servo pulse block
`timescale 1ns/1ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("mismatch %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module spio_top_tb_top;
  import spio_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, v;
  logic ack, fa, fb, fi, sm, pm, rs, rdir, am, ao, pls, sgn, busy;
  logic enc = 1'b0, go = 1'b0, fwd = 1'b0, neg = 1'b0, clr = 1'b0;
  // Encoder direction and speed signs, so no rule input is tied off
  logic edir = 1'b1, mneg = 1'b0, cneg = 1'b0;
  logic [15:0] ms = 16'h0, sc = 16'h0;
  logic [2:0] kind = 3'h0;
  logic [7:0] hp = 8'h1e;
  logic exp_dir = 1'b0, pa = 1'b0, pi = 1'b0, b_at = 1'b0, b0;
  int err_count = 0, n_checks = 0, n_step, bad_dir, a_rise, i_rise, k, d;
  logic [7:0] ra [6] = '{ADDR_PPR, ADDR_WINDOW, ADDR_FORM, ADDR_FILTER,
                         ADDR_MODE, 8'h24};
  logic [15:0] rv [6] = '{PPR_RESET, WINDOW_RESET, FORM_RESET,
                          FILTER_RESET, MODE_RESET, 16'h0000};
  logic [15:0] pv [6] = '{16'd15, 16'd16, 16'd8192, 16'd8193, 16'd16384,
                          16'd100};
  logic [5:0] pe = 6'b011001;
  int kd [7] = '{0, 1, 2, 2, 2, 0, 1};
  int ml [7] = '{1, 1, 1, 2, 4, 1, 1};
  always #5 clk_i = ~clk_i;
  // Small encoder resolution keeps one turn short
  spio_top #(.ENC_RES(24'd8192)) spio_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ref_pulse_in_i(pls),
    .ref_sign_in_i(sgn), .enc_step_i(enc), .enc_dir_i(edir),
    .motor_speed_i(ms), .motor_speed_neg_i(mneg), .speed_cmd_i(sc),
    .speed_cmd_neg_i(cneg), .feedback_phase_a_o(fa),
    .feedback_phase_b_o(fb), .feedback_index_o(fi),
    .speed_match_out_o(sm), .position_mode_o(pm), .ref_step_o(rs),
    .ref_dir_o(rdir), .alarm_mismatch_o(am), .alarm_overspeed_o(ao));
  spio_host spio_host_inst (.clk_i(clk_i), .go_i(go), .kind_i(kind),
    .neg_i(neg), .fwd_i(fwd), .hp_i(hp), .pulse_o(pls), .sign_o(sgn),
    .busy_o(busy));
  // Event counters, cleared through clr to keep one writer
  always @(posedge clk_i) begin
    pa <= fa;
    pi <= fi;
    if (clr) begin
      n_step <= 0;
      bad_dir <= 0;
      a_rise <= 0;
      i_rise <= 0;
    end else begin
      if (rs === 1'b1) n_step <= n_step + 1;
      if (rs === 1'b1 && rdir !== exp_dir) bad_dir <= bad_dir + 1;
      if (fa === 1'b1 && pa === 1'b0) a_rise <= a_rise + 1;
      if (fa === 1'b1 && pa === 1'b0) b_at <= fb;
      if (fi === 1'b1 && pi === 1'b0) i_rise <= i_rise + 1;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // One classic cycle, held until ack is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= wd;
    sel <= 4'hf;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      err_count++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    xfer(1'b1, a, x, r);
  endtask : wr
  task automatic app();
    wr(ADDR_APPLY, 32'h0);
    repeat (3) @(posedge clk_i);
  endtask : app
  task automatic clear();
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask : clear
  task automatic spd(input logic [15:0] s, input logic [15:0] w,
                     input logic e);
    wr(ADDR_WINDOW, {16'h0, w});
    ms <= s;
    repeat (4) @(posedge clk_i);
    `CHK(sm, e)
  endtask : spd
  task automatic burst(input logic [2:0] kk, input logic ng,
                       input logic dr, input logic [7:0] h);
    int i;
    clear();
    kind <= kk;
    neg <= ng;
    fwd <= dr;
    exp_dir <= dr;
    hp <= h;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 4000 && busy === 1'b1; i++) @(posedge clk_i);
    if (i == 4000) begin
      err_count++;
      tally_and_finish();
    end
    repeat (100) @(posedge clk_i);
  endtask : burst
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, unmapped place ignores writes and reads zero
    wr(8'h24, 32'h0000_ffff);
    for (k = 0; k < 6; k++) begin
      xfer(1'b0, ra[k], 32'h0, v);
      `CHK(v, {16'h0, rv[k]})
    end
    $display("test registers done");
    sc <= 16'd2000;
    spd(16'd2009, 16'd10, 1'b1);
    spd(16'd2010, 16'd10, 1'b0);
    spd(16'd1991, 16'd10, 1'b1);
    spd(16'd1990, 16'd10, 1'b0);
    // Opposite signs add; equal signs subtract
    sc <= 16'd4;
    cneg <= 1'b1;
    spd(16'd5, 16'd10, 1'b1);
    spd(16'd6, 16'd10, 1'b0);
    mneg <= 1'b1;
    spd(16'd6, 16'd10, 1'b1);
    sc <= 16'd2000;
    cneg <= 1'b0;
    mneg <= 1'b0;
    spd(16'd2000, 16'd0, 1'b0);
    spd(16'd2099, 16'd200, 1'b1);
    spd(16'd2100, 16'd200, 1'b0);
    xfer(1'b0, ADDR_WINDOW, 32'h0, v);
    `CHK(v, {16'h0, WINDOW_MAX})
    ms <= 16'd6001;
    repeat (4) @(posedge clk_i);
    `CHK(ao, 1'b1)
    xfer(1'b0, ADDR_STATUS, 32'h0, v);
    `CHK(v[ST_OVERSPEED], 1'b1)
    xfer(1'b0, ADDR_SPEED, 32'h0, v);
    `CHK(v, 32'd6001)
    ms <= 16'd6000;
    repeat (4) @(posedge clk_i);
    `CHK(ao, 1'b0)
    $display("test speed done");
    wr(ADDR_PPR, {16'h0, pv[0]});
    `CHK(am, 1'b0)
    for (k = 0; k < 6; k++) begin
      wr(ADDR_PPR, {16'h0, pv[k]});
      app();
      `CHK(am, pe[k])
    end
    $display("test mismatch done");
    ms <= 16'd2000;
    wr(ADDR_MODE, 32'h0000_0020);
    app();
    `CHK(pm, 1'b0)
    `CHK(sm, 1'b1)
    wr(ADDR_MODE, 32'h0000_0010);
    `CHK(pm, 1'b0)
    app();
    `CHK(pm, 1'b1)
    `CHK(sm, 1'b0)
    // Every pulse form, both directions
    for (k = 0; k < 7; k++) begin
      wr(ADDR_FORM, 32'(k));
      app();
      for (d = 0; d < 2; d++) begin
        burst(3'(kd[k]), k == 5, d[0], 8'd30);
        `CHK(n_step, 3 * ml[k])
        `CHK(bad_dir, 0)
      end
    end
    wr(ADDR_FORM, 32'h0);
    wr(ADDR_FILTER, 32'h0000_0100);
    app();
    burst(3'd0, 1'b0, 1'b1, 8'd30);
    `CHK(n_step, 0)
    burst(3'd0, 1'b0, 1'b1, 8'd80);
    `CHK(n_step, 3)
    // Every form ran both ways, so only the last burst is left
    xfer(1'b0, ADDR_POS, 32'h0, v);
    `CHK(v, 32'd3)
    wr(ADDR_FILTER, 32'h0);
    app();
    $display("test pulse forms done");
    // One turn each, second with A/B swapped
    for (d = 0; d < 2; d++) begin
      clear();
      for (k = 0; k < 8192; k++) begin
        enc <= 1'b1;
        @(posedge clk_i);
        enc <= 1'b0;
        @(posedge clk_i);
      end
      repeat (12000) @(posedge clk_i);
      `CHK(a_rise, 100)
      `CHK(i_rise, 1)
      if (d == 0) b0 = b_at;
      else `CHK(b_at, ~b0)
      wr(ADDR_FILTER, 32'h0000_0010);
      app();
    end
    // Half turn backwards, swap still on: B at A rise as unswapped forward
    edir <= 1'b0;
    clear();
    for (k = 0; k < 4096; k++) begin
      enc <= 1'b1;
      @(posedge clk_i);
      enc <= 1'b0;
      @(posedge clk_i);
    end
    repeat (4000) @(posedge clk_i);
    `CHK(a_rise, 50)
    `CHK(i_rise, 0)
    `CHK(b_at, b0)
    edir <= 1'b1;
    $display("test feedback done");
    tally_and_finish();
  end
endmodule : spio_top_tb_top
